// [verilog/rtdps_pkg.sv]
package rtdps_pkg;

    // record numbers for parameter access
    localparam logic [7:0] REC_ALARM_WIRE = 8'h00;
    localparam logic [7:0] REC_UNIT_REJ   = 8'h01;
    localparam logic [7:0] REC_CH0        = 8'h80;
    localparam logic [7:0] REC_CH3        = 8'h83;
    // object dictionary indices and slave subindices
    localparam logic [15:0] OBJ_INDEX_BASE = 16'h3100;
    localparam logic [15:0] OBJ_INDEX_LAST = 16'h3107;
    localparam logic [7:0]  SUBIDX_FIRST   = 8'h01;
    localparam logic [7:0]  SUBIDX_LAST    = 8'h08;
    localparam int          PARAM_BYTES    = 12;
    localparam int          NUM_CH         = 4;

    // byte values and reset values
    localparam logic [7:0] ALARM_ON       = 8'h40;
    localparam logic [7:0] ALARM_OFF      = 8'h00;
    localparam logic [7:0] RST_ALARM      = 8'h00;
    localparam logic [7:0] RST_WIRE       = 8'h00;
    localparam logic [7:0] RST_UNIT       = 8'h00;
    localparam logic [7:0] RST_REJ        = 8'h02;
    localparam logic [7:0] RST_FN         = 8'h50;
    localparam logic [7:0] FN_OFF         = 8'hff;
    localparam logic [7:0] WIRE_MASK      = 8'h0f;
    localparam logic [7:0] SEL_MASK       = 8'h03;
    localparam logic [1:0] UNIT_C         = 2'h0;
    localparam logic [1:0] UNIT_F         = 2'h1;
    localparam logic [1:0] UNIT_K         = 2'h2;
    localparam logic [1:0] REJ_60HZ       = 2'h1;
    localparam logic [1:0] REJ_50HZ       = 2'h2;
    // function number groups
    localparam logic [7:0] FN_2W          = 8'h50;
    localparam logic [7:0] FN_3W          = 8'h58;
    localparam logic [7:0] FN_4W          = 8'h60;
    localparam logic [2:0] SENS_LAST      = 3'h4;

    // scaling limits, tenths of a degree
    localparam logic signed [15:0] PT_MIN = -16'sd2000;
    localparam logic signed [15:0] PT_MAX = 16'sd8500;
    localparam logic signed [15:0] PT_OVR = 16'sd10000;
    localparam logic signed [15:0] PT_UND = -16'sd2430;
    localparam logic signed [15:0] NI_MIN = -16'sd600;
    localparam logic signed [15:0] NI_MAX = 16'sd2500;
    localparam logic signed [15:0] NI_OVR = 16'sd2950;
    localparam logic signed [15:0] NI_UND = -16'sd1050;
    localparam logic signed [15:0] N1_MIN = -16'sd800;
    localparam logic signed [15:0] N1_MAX = 16'sd3200;
    localparam logic signed [15:0] N1_OVR = 16'sd4000;
    localparam logic signed [15:0] N1_UND = -16'sd1000;

    // master-side registers on AXI4-Lite
    localparam logic [7:0] A_CMD    = 8'h00; // [31] go, [23:16] rec, [15:8] offs, [7:0] data, [30] write
    localparam logic [7:0] A_RDATA  = 8'h04;
    localparam logic [7:0] A_STAT   = 8'h08;
    localparam logic [7:0] A_MASK   = 8'h0c;
    localparam logic [7:0] A_SAMPLE = 8'h10; // [17:16] channel, [15:0] raw tenths
    localparam logic [7:0] A_VALUE  = 8'h14; // 0x14..0x20 four channels
    localparam int ST_DONE = 0;
    localparam int ST_ERR  = 1;
    localparam int ST_DIAG = 2;
    localparam logic [1:0] RESP_OK  = 2'h0;
    localparam logic [1:0] RESP_ERR = 2'h2;

    typedef enum logic [1:0] {SENS_PT, SENS_NI, SENS_N120, SENS_NONE} rtdps_sens_t;

    // decode a function number into a sensor class; invalid or off gives none
    function automatic rtdps_sens_t rtdps_decode(input logic [7:0] fn);
        logic [7:0] base;
        logic [2:0] lo;
        base = {fn[7:3], 3'h0};
        lo   = fn[2:0];
        if ((base != FN_2W && base != FN_3W && base != FN_4W) || lo > SENS_LAST)
            return SENS_NONE;
        else if (lo < 3'h2)
            return SENS_PT;
        else if (lo < 3'h4)
            return SENS_NI;
        else
            return SENS_N120;
    endfunction

endpackage

// [verilog/rtdps_if.sv]
`timescale 1ns/10ps
// backplane parameter channel between head station and module
interface rtdps_if;
    logic        req;
    logic        wr;
    logic [7:0]  rec;
    logic [7:0]  offs;
    logic [7:0]  wdata;
    logic        ack;
    logic        err;
    logic [7:0]  rdata;
    logic        smp_valid;
    logic [1:0]  smp_ch;
    logic [15:0] smp_raw;
    logic [15:0] value [4];
    logic [3:0]  ch_active;
    logic        diag_irq;

    modport module_end (input req, wr, rec, offs, wdata, smp_valid, smp_ch, smp_raw,
                        output ack, err, rdata, value, ch_active, diag_irq);
    modport head_end (output req, wr, rec, offs, wdata, smp_valid, smp_ch, smp_raw,
                      input ack, err, rdata, value, ch_active, diag_irq);
endinterface

// [verilog/rtdps_scale.sv]
`timescale 1ns/10ps
// clamp one raw reading to the limits of its sensor class
module rtdps_scale
    import rtdps_pkg::*;
(
    // sensor and reading
    input  wire rtdps_sens_t        sens,
    input  wire logic signed [15:0] raw,
    // result
    output logic signed [15:0]      scaled,
    output logic                    out_of_range
);
    logic signed [15:0] lo_lim;
    logic signed [15:0] hi_lim;

    // limits per class; an inactive class reads as zero
    always_comb begin
        case (sens)
            SENS_PT:   begin lo_lim = PT_UND; hi_lim = PT_OVR; end
            SENS_NI:   begin lo_lim = NI_UND; hi_lim = NI_OVR; end
            SENS_N120: begin lo_lim = N1_UND; hi_lim = N1_OVR; end
            default:   begin lo_lim = 16'sh0000; hi_lim = 16'sh0000; end
        endcase
    end

    // saturate at the under/overrange figures, flag anything at or beyond either figure
    always_comb begin
        if (raw > hi_lim)
            scaled = hi_lim;
        else if (raw < lo_lim)
            scaled = lo_lim;
        else
            scaled = raw;
        out_of_range = (sens == SENS_NONE) ? 1'b0 : (raw >= hi_lim || raw <= lo_lim);
    end
endmodule

// [verilog/rtdps_module.sv]
`timescale 1ns/10ps
module rtdps_module
    import rtdps_pkg::*;
(
    // clock and reset
    input  wire logic SYS_CLK,
    input  wire logic RST_B,
    // straps
    input  wire logic TWO_CH_MODE,
    input  wire logic STOP_STATE,
    // backplane
    rtdps_if.module_end BP,
    // status
    output logic       PARAM_ERR,
    output logic [1:0] UNIT_SEL,
    output logic [1:0] REJ_SEL,
    output logic [3:0] WIRE_EN
);
    logic [7:0]  fault_alarm_enable;
    logic [7:0]  open_wire_detect_enable;
    logic [7:0]  temperature_unit_select;
    logic [7:0]  mains_rejection_select;
    logic [7:0]  channel_range_code [NUM_CH];
    logic [7:0]  wr_byte;
    logic [2:0]  wr_sel;
    logic        wr_hit;
    logic        wr_ok;
    logic [15:0] dict_idx;
    logic        dict_hit;
    logic [7:0]  next_rdata;
    logic        ack;
    logic        err;
    logic [7:0]  rdata;
    logic        param_err;
    rtdps_sens_t sens [NUM_CH];
    logic signed [15:0] scaled [NUM_CH];
    logic        oor [NUM_CH];
    logic [15:0] value [NUM_CH];
    logic        diag_irq;

    // list position of a dictionary index; the low byte counts the slots from 3100h
    function automatic logic [2:0] rtdps_list_pos(input logic [7:0] idx_lo);
        logic [7:0] pos;
        pos = idx_lo - OBJ_INDEX_BASE[7:0];
        return pos[2:0];
    endfunction

    // dictionary access: the record byte carries the index high byte, the offset byte the low byte
    always_comb begin
        dict_idx = {BP.rec, BP.offs};
        dict_hit = (dict_idx >= OBJ_INDEX_BASE) && (dict_idx <= OBJ_INDEX_LAST);
    end

    // parameter slots in list order:
    //   slot 0 alarm enable,      record 00h offset 0
    //   slot 1 open-wire enable,  record 00h offset 1
    //   slot 2 unit select,       record 01h offset 0
    //   slot 3 rejection select,  record 01h offset 1
    //   slots 4..7 channel codes, records 80h..83h offset 0
    // dictionary indices 3100h..3107h reach the same slots; slots 0 and 1
    // stay write-protected outside the stopped state on either path
    always_comb begin
        wr_hit = 1'b1;
        wr_sel = 3'h0;
        if (BP.rec == REC_ALARM_WIRE && BP.offs < 8'h02)
            wr_sel = {2'b00, BP.offs[0]};
        else if (BP.rec == REC_UNIT_REJ && BP.offs < 8'h02)
            wr_sel = {2'b01, BP.offs[0]};
        else if (BP.rec >= REC_CH0 && BP.rec <= REC_CH3 && BP.offs == 8'h00)
            wr_sel = {1'b1, BP.rec[1:0]};
        else if (dict_hit)
            wr_sel = rtdps_list_pos(BP.offs);
        else
            wr_hit = 1'b0;
    end

    // record 00h may only change while the system is stopped
    // a refused write still earns its ack, with err set, so the head never hangs
    assign wr_ok = wr_hit && !(BP.wr && wr_sel[2:1] == 2'b00 && !STOP_STATE);
    assign wr_byte = BP.wdata;

    // parameter byte storage
    // reserved bits of the open-wire, unit and rejection bytes are masked on the way in, so they read back zero
    always_ff @(posedge SYS_CLK) begin
        if (!RST_B) begin
            fault_alarm_enable      <= RST_ALARM;
            open_wire_detect_enable <= RST_WIRE;
            temperature_unit_select <= RST_UNIT;
            mains_rejection_select  <= RST_REJ;
            for (int i = 0; i < NUM_CH; i++)
                channel_range_code[i] <= (TWO_CH_MODE && i >= 2) ? FN_OFF : RST_FN;
        end else if (BP.req && BP.wr && wr_ok) begin
            case (wr_sel)
                3'h0:    fault_alarm_enable      <= wr_byte;
                3'h1:    open_wire_detect_enable <= wr_byte & WIRE_MASK;
                3'h2:    temperature_unit_select <= wr_byte & SEL_MASK;
                3'h3:    mains_rejection_select  <= wr_byte & SEL_MASK;
                default: channel_range_code[wr_sel[1:0]] <= wr_byte;
            endcase
        end
    end

    // read mux
    // shares the write decode, so a read always names the slot a write would hit
    always_comb begin
        case (wr_sel)
            3'h0:    next_rdata = fault_alarm_enable;
            3'h1:    next_rdata = open_wire_detect_enable;
            3'h2:    next_rdata = temperature_unit_select;
            3'h3:    next_rdata = mains_rejection_select;
            default: next_rdata = channel_range_code[wr_sel[1:0]];
        endcase
    end

    // one-cycle answer to each request
    // the request drops while ack is high, so every request earns exactly one pulse
    always_ff @(posedge SYS_CLK) begin
        if (!RST_B) begin
            ack   <= 1'b0;
            err   <= 1'b0;
            rdata <= 8'h00;
        end else begin
            ack   <= BP.req && !ack;
            err   <= BP.req && !ack && !wr_ok;
            rdata <= (BP.req && wr_hit) ? next_rdata : 8'h00;
        end
    end

    // decode each channel and clamp the supplied reading
    // every channel sees the same reading bus; smp_ch picks which one latches
    for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
        assign sens[c] = rtdps_decode(channel_range_code[c]);
        rtdps_scale u_scale (
            .sens         (sens[c]),
            .raw          (BP.smp_raw),
            .scaled       (scaled[c]),
            .out_of_range (oor[c])
        );
    end

    // latch values only for active channels; inactive ones hold zero
    // no conversion happens here: the reading arrives in tenths already
    always_ff @(posedge SYS_CLK) begin
        if (!RST_B) begin
            for (int i = 0; i < NUM_CH; i++)
                value[i] <= 16'h0000;
        end else begin
            for (int i = 0; i < NUM_CH; i++) begin
                if (sens[i] == SENS_NONE)
                    value[i] <= 16'h0000;
                else if (BP.smp_valid && BP.smp_ch == i[1:0])
                    value[i] <= scaled[i];
            end
        end
    end

    // parameter error: a channel code that is neither defined nor off
    always_ff @(posedge SYS_CLK) begin
        if (!RST_B)
            param_err <= 1'b0;
        else begin
            param_err <= 1'b0;
            for (int i = 0; i < NUM_CH; i++)
                if (sens[i] == SENS_NONE && channel_range_code[i] != FN_OFF)
                    param_err <= 1'b1;
        end
    end

    // diagnostic interrupt only when the alarm byte is exactly 40h
    // a pulse per out-of-range sample, a level while param_err holds; the head keeps the sticky copy that software clears
    always_ff @(posedge SYS_CLK) begin
        if (!RST_B)
            diag_irq <= 1'b0;
        else
            diag_irq <= (fault_alarm_enable == ALARM_ON) &&
                        (param_err || (BP.smp_valid && oor[BP.smp_ch]));
    end

    assign BP.ack       = ack;
    assign BP.err       = err;
    assign BP.rdata     = rdata;
    assign BP.value     = value;
    assign BP.diag_irq  = diag_irq;
    assign BP.ch_active = {sens[3] != SENS_NONE, sens[2] != SENS_NONE,
                           sens[1] != SENS_NONE, sens[0] != SENS_NONE};
    assign PARAM_ERR    = param_err;
    assign UNIT_SEL     = temperature_unit_select[1:0];
    assign REJ_SEL      = mains_rejection_select[1:0];
    assign WIRE_EN      = open_wire_detect_enable[3:0];
endmodule

// [verilog/rtdps_head.sv]
`timescale 1ns/10ps
// head station: AXI4-Lite registers turn into backplane parameter accesses
module rtdps_head
    import rtdps_pkg::*;
(
    // clock and reset
    input  wire logic SYS_CLK,
    input  wire logic RST_B,
    // axi4-lite slave
    input  wire logic        AWVALID,
    output logic             AWREADY,
    input  wire logic [7:0]  AWADDR,
    input  wire logic        WVALID,
    output logic             WREADY,
    input  wire logic [31:0] WDATA,
    input  wire logic [3:0]  WSTRB,
    output logic             BVALID,
    input  wire logic        BREADY,
    output logic [1:0]       BRESP,
    input  wire logic        ARVALID,
    output logic             ARREADY,
    input  wire logic [7:0]  ARADDR,
    output logic             RVALID,
    input  wire logic        RREADY,
    output logic [31:0]      RDATA,
    output logic [1:0]       RRESP,
    // interrupt
    output logic             IRQ,
    // backplane
    rtdps_if.head_end        BP
);
    logic        aw_got, w_got, busy, smp_go;
    logic [7:0]  aw_addr;
    logic [31:0] w_data;
    logic [31:0] cmd, smp;
    logic [7:0]  rdat;
    logic [2:0]  status, mask;

    // capture address and data in either order
    always_ff @(posedge SYS_CLK) begin
        if (!RST_B) begin
            aw_got <= 1'b0; w_got <= 1'b0; aw_addr <= 8'h00; w_data <= 32'h0;
        end else if (BVALID && BREADY) begin
            aw_got <= 1'b0; w_got <= 1'b0;
        end else begin
            if (AWVALID && AWREADY) begin aw_got <= 1'b1; aw_addr <= AWADDR; end
            if (WVALID && WREADY) begin w_got <= 1'b1; w_data <= WDATA; end
        end
    end
    assign AWREADY = !aw_got;
    assign WREADY  = !w_got;

    // write response and register updates; hardware sets win over clears
    always_ff @(posedge SYS_CLK) begin
        if (!RST_B) begin
            BVALID <= 1'b0; BRESP <= RESP_OK; cmd <= 32'h0; mask <= 3'h0;
            status <= 3'h0; busy <= 1'b0; rdat <= 8'h00; smp <= 32'h0; smp_go <= 1'b0;
        end else begin
            smp_go <= 1'b0;
            if (BP.ack) begin
                busy <= 1'b0;
                rdat <= BP.rdata;
            end
            if (aw_got && w_got && !BVALID) begin
                BVALID <= 1'b1;
                BRESP  <= (aw_addr <= A_VALUE + 8'h0c && aw_addr[1:0] == 2'b00) ? RESP_OK : RESP_ERR;
                case (aw_addr)
                    A_CMD:    if (!busy && w_data[31]) begin cmd <= w_data; busy <= 1'b1; end
                    A_MASK:   mask <= w_data[2:0];
                    A_SAMPLE: begin smp <= w_data; smp_go <= 1'b1; end
                    default:  ;
                endcase
            end else if (BVALID && BREADY)
                BVALID <= 1'b0;
            // write-one-to-clear then sticky set
            for (int i = 0; i < 3; i++) begin
                if (aw_got && w_got && !BVALID && aw_addr == A_STAT && w_data[i] && WSTRB[0])
                    status[i] <= 1'b0;
            end
            if (BP.ack) status[ST_DONE] <= 1'b1;
            if (BP.ack && BP.err) status[ST_ERR] <= 1'b1;
            if (BP.diag_irq) status[ST_DIAG] <= 1'b1;
        end
    end

    // read channel
    always_ff @(posedge SYS_CLK) begin
        if (!RST_B) begin
            RVALID <= 1'b0; RDATA <= 32'h0; RRESP <= RESP_OK;
        end else if (ARVALID && ARREADY) begin
            RVALID <= 1'b1;
            RRESP  <= RESP_OK;
            case (ARADDR)
                A_CMD:    RDATA <= cmd;
                A_RDATA:  RDATA <= {24'h0, rdat};
                A_STAT:   RDATA <= {28'h0, busy, status};
                A_MASK:   RDATA <= {29'h0, mask};
                A_SAMPLE: RDATA <= smp;
                A_VALUE, A_VALUE + 8'h04, A_VALUE + 8'h08, A_VALUE + 8'h0c:
                    RDATA <= {BP.ch_active[ARADDR[3:2] - 2'h1], 15'h0, BP.value[ARADDR[3:2] - 2'h1]};
                default:  begin RDATA <= 32'h0; RRESP <= RESP_ERR; end
            endcase
        end else if (RVALID && RREADY)
            RVALID <= 1'b0;
    end
    assign ARREADY = !RVALID;

    // backplane request held until acknowledged
    assign BP.req       = busy && !BP.ack;
    assign BP.wr        = cmd[30];
    assign BP.rec       = cmd[23:16];
    assign BP.offs      = cmd[15:8];
    assign BP.wdata     = cmd[7:0];
    assign BP.smp_valid = smp_go;
    assign BP.smp_ch    = smp[17:16];
    assign BP.smp_raw   = smp[15:0];
    assign IRQ          = |(status & mask);
endmodule

// [sim/rtdps_asserts.sv]
`timescale 1ns/10ps
// handshake and scaling checks on the backplane between the two ends
module rtdps_asserts
    import rtdps_pkg::*;
(
    // clock and reset
    input wire logic        SYS_CLK,
    input wire logic        RST_B,
    // backplane
    input wire logic        req,
    input wire logic        wr,
    input wire logic [7:0]  rec,
    input wire logic [7:0]  offs,
    input wire logic [7:0]  wdata,
    input wire logic        ack,
    input wire logic        err,
    input wire logic        smp_valid,
    input wire logic [1:0]  smp_ch,
    input wire logic [15:0] smp_raw,
    input wire logic [15:0] value [4],
    input wire logic [3:0]  ch_active
);
    default clocking @(posedge SYS_CLK); endclocking
    default disable iff (!RST_B);
    // only records 00h, 01h, 80h..83h and indices 3100h..3107h exist
    wire logic mapped = rec == REC_ALARM_WIRE || rec == REC_UNIT_REJ || rec[7:2] == 6'h20
                        || ({rec, offs} >= OBJ_INDEX_BASE && {rec, offs} <= OBJ_INDEX_LAST);

    ack_one_cycle_a: assert property ($rose(req) |=> ack)
        else $error("no ack one cycle after request");
    ack_pulse_a: assert property (ack |=> !ack)
        else $error("ack held longer than one cycle");
    err_with_ack_a: assert property (err |-> ack)
        else $error("error flag without ack");
    unmapped_err_a: assert property ($rose(req) && !mapped |=> err)
        else $error("unmapped record not refused");
    channel_read_a: assert property ($rose(req) && !wr && rec[7:2] == 6'h20 && offs == 8'h00 |=> !err)
        else $error("channel record read refused");
    off_channel_a: assert property ($rose(req) && wr && rec == REC_CH0 && wdata == FN_OFF |-> ##2 !ch_active[0])
        else $error("channel still active after off code");
    dark_hold_a: assert property (smp_valid && smp_ch == 2'h0 && !ch_active[0] |=> $stable(value[0]))
        else $error("inactive channel took a reading");
    // channel 1 readings inside the Ni nominal range pass through unchanged in any active class
    pass_mid_a: assert property (smp_valid && smp_ch == 2'h1 && ch_active[1] && $signed(smp_raw) >= NI_MIN
        && $signed(smp_raw) <= NI_MAX |=> value[1] == $past(smp_raw))
        else $error("nominal reading altered");
    pt_bounds_a: assert property (smp_valid && smp_ch == 2'h0 && ch_active[0] |=>
        $signed(value[0]) <= PT_OVR && $signed(value[0]) >= PT_UND)
        else $error("value outside widest limits");
    cover property ($rose(req) && wr && err);
    cover property (smp_valid && !ch_active[smp_ch]);
    cover property (smp_valid && smp_ch == 2'h1 && ch_active[1]);
endmodule

// [sim/rtd_input_param_and_scaling_bench.sv]
`timescale 1ns/10ps
// axi4-lite master on the head end, module end behind the backplane
module rtd_input_param_and_scaling_bench;
    import rtdps_pkg::*;
    logic        clk = 1'b0, rst_b = 1'b0, two_ch = 1'b0, stop_st = 1'b0;
    logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [7:0]  awaddr = 8'h00, araddr = 8'h00, b, fn;
    logic [31:0] wdata = 32'h0, rdata, q;
    logic        awready, wready, bvalid, arready, rvalid, irq, param_err, e;
    logic [1:0]  bresp, rresp, unit_sel, rej_sel, rs;
    logic [3:0]  wire_en;
    logic [15:0] ov, un;
    logic [7:0]  bad [5] = '{8'h55, 8'h57, 8'h5d, 8'h65, 8'h40};
    int          n_errors = 0, tests_run = 0, i;

    rtdps_if bp ();
    rtdps_head i_rtdps_head (.SYS_CLK(clk), .RST_B(rst_b), .AWVALID(awvalid), .AWREADY(awready),
        .AWADDR(awaddr), .WVALID(wvalid), .WREADY(wready), .WDATA(wdata), .WSTRB(4'hf), .BVALID(bvalid),
        .BREADY(bready), .BRESP(bresp), .ARVALID(arvalid), .ARREADY(arready), .ARADDR(araddr),
        .RVALID(rvalid), .RREADY(rready), .RDATA(rdata), .RRESP(rresp), .IRQ(irq), .BP(bp));
    rtdps_module i_rtdps_module (.SYS_CLK(clk), .RST_B(rst_b), .TWO_CH_MODE(two_ch), .STOP_STATE(stop_st),
        .BP(bp), .PARAM_ERR(param_err), .UNIT_SEL(unit_sel), .REJ_SEL(rej_sel), .WIRE_EN(wire_en));
    rtdps_asserts i_rtdps_asserts (.SYS_CLK(clk), .RST_B(rst_b), .req(bp.req), .wr(bp.wr), .rec(bp.rec),
        .offs(bp.offs), .wdata(bp.wdata), .ack(bp.ack), .err(bp.err), .smp_valid(bp.smp_valid),
        .smp_ch(bp.smp_ch), .smp_raw(bp.smp_raw), .value(bp.value), .ch_active(bp.ch_active));

    // 200 MHz clock
    initial begin
        forever #2.5 clk = ~clk;
    end

    // one axi transfer; ready is sampled at the falling edge, where it has settled
    task automatic ax(input logic w, input logic [7:0] a, input logic [31:0] d);
        logic ta, tw, tr, tb;
        @(posedge clk);
        awvalid <= w;
        wvalid <= w;
        bready <= w;
        arvalid <= !w;
        rready <= !w;
        awaddr <= a;
        araddr <= a;
        wdata <= d;
        for (int n = 0; n < 100; n++) begin
            @(negedge clk);
            ta = awvalid && awready;
            tw = wvalid && wready;
            tr = arvalid && arready;
            tb = w ? bvalid : rvalid;
            q = rdata;
            rs = w ? bresp : rresp;
            @(posedge clk);
            if (ta) awvalid <= 1'b0;
            if (tw) wvalid <= 1'b0;
            if (tr) arvalid <= 1'b0;
            if (tb) begin
                bready <= 1'b0;
                rready <= 1'b0;
                break;
            end
        end
        if (!tb) n_errors++;
    endtask

    task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
        tests_run++;
        if (got !== ex) begin
            $display("mismatch %s expected %h seen %h", nm, ex, got);
            n_errors++;
        end
    endtask

    // one parameter access; polls status until done or error, then clears both
    task automatic par(input logic w, input logic [7:0] rc, input logic [7:0] of, input logic [7:0] dt);
        ax(1'b1, A_CMD, {1'b1, w, 6'h0, rc, of, dt});
        ax(1'b0, A_STAT, 32'h0);
        for (int n = 0; n < 40 && q[ST_ERR:ST_DONE] === 2'b00; n++) ax(1'b0, A_STAT, 32'h0);
        if (q[ST_ERR:ST_DONE] === 2'b00) n_errors++;
        e = q[ST_ERR];
        ax(1'b0, A_RDATA, 32'h0);
        b = q[7:0];
        ax(1'b1, A_STAT, 32'h3);
    endtask

    // feed a raw reading, read back active bit and value; bits 30:16 are forced to zero
    task automatic smp(input logic [1:0] ch, input logic [15:0] raw);
        ax(1'b1, A_SAMPLE, {14'h0, ch, raw});
        ax(1'b0, A_VALUE + {4'h0, ch, 2'h0}, 32'h0);
        q = {q[31], 15'h0, q[15:0]};
    endtask

    task automatic do_reset();
        rst_b <= 1'b0;
        repeat (20) @(posedge clk);
        rst_b <= 1'b1;
    endtask

    task automatic conclude();
        if (n_errors == 0 && tests_run > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // the whole run takes well under two thousand cycles
    initial begin
        repeat (60000) @(posedge clk);
        n_errors++;
        conclude();
    end

    initial begin
        do_reset();
        for (i = 0; i < 8; i++) begin
            par(1'b0, i < 2 ? REC_ALARM_WIRE : i < 4 ? REC_UNIT_REJ : 8'(REC_CH0 + i - 4), 8'(i < 4 ? i % 2 : 0), 8'h0);
            chk("default", i == 3 ? RST_REJ : i > 3 ? RST_FN : 8'h00, b);
        end
        // alarm record is refused outside stop
        par(1'b1, REC_ALARM_WIRE, 8'h00, ALARM_ON);
        chk("stop refuse", 32'h1, {31'h0, e});
        stop_st <= 1'b1;
        par(1'b1, REC_ALARM_WIRE, 8'h00, ALARM_ON);
        par(1'b1, REC_ALARM_WIRE, 8'h01, 8'hf5);
        par(1'b0, REC_ALARM_WIRE, 8'h01, 8'h00);
        chk("wire byte", 32'h5, {24'h0, b});
        chk("wire en", 32'h5, {28'h0, wire_en});
        for (i = 0; i < 3; i++) begin
            par(1'b1, REC_UNIT_REJ, 8'h00, 8'(8'hfc | i));
            par(1'b0, REC_UNIT_REJ, 8'h00, 8'h00);
            chk("unit byte", 32'(i), {24'h0, b});
            chk("unit sel", 32'(i), {30'h0, unit_sel});
            if (i > 0) par(1'b1, REC_UNIT_REJ, 8'h01, 8'(8'hf0 | i));
            if (i > 0) chk("rej sel", 32'(i), {30'h0, rej_sel});
            if (i > 0) par(1'b0, REC_UNIT_REJ, 8'h01, 8'h00);
            if (i > 0) chk("rej byte", 32'(i), {24'h0, b});
        end
        // dictionary indices reach the same slots in list order
        par(1'b0, OBJ_INDEX_BASE[15:8], 8'h03, 8'h00);
        chk("index read", {30'h0, REJ_50HZ}, {24'h0, b});
        par(1'b1, OBJ_INDEX_BASE[15:8], 8'h05, 8'h62);
        par(1'b0, 8'h81, 8'h00, 8'h00);
        chk("index write", 32'h62, {24'h0, b});
        // overrange with the alarm on sets diag, seen through the mask
        ax(1'b1, A_MASK, 32'h4);
        chk("bresp ok", {30'h0, RESP_OK}, {30'h0, rs});
        smp(2'h0, 16'h7fff);
        chk("pt over", {1'b1, 15'h0, PT_OVR}, q);
        chk("irq on", 32'h1, {31'h0, irq});
        ax(1'b1, A_MASK, 32'h0);
        @(negedge clk);
        chk("irq masked", 32'h0, {31'h0, irq});
        ax(1'b1, A_MASK, 32'h4);
        ax(1'b1, A_STAT, 32'h4);
        @(negedge clk);
        chk("irq cleared", 32'h0, {31'h0, irq});
        par(1'b1, REC_ALARM_WIRE, 8'h00, ALARM_OFF);
        smp(2'h0, 16'h8000);
        chk("pt under", {1'b1, 15'h0, PT_UND}, q);
        chk("irq off", 32'h0, {31'h0, irq});
        // every defined code: limits follow the sensor class in each wiring group
        for (i = 0; i < 15; i++) begin
            fn = 8'(8'h50 + 8 * (i / 5) + i % 5);
            ov = i % 5 < 2 ? PT_OVR : i % 5 < 4 ? NI_OVR : N1_OVR;
            un = i % 5 < 2 ? PT_UND : i % 5 < 4 ? NI_UND : N1_UND;
            par(1'b1, 8'h81, 8'h00, fn);
            smp(2'h1, 16'h7fff);
            chk("over", {1'b1, 15'h0, ov}, q);
            smp(2'h1, 16'h8000);
            chk("under", {1'b1, 15'h0, un}, q);
            smp(2'h1, 16'hff9c);
            chk("nominal", {1'b1, 15'h0, 16'hff9c}, q);
        end
        // undefined codes keep the channel dark
        for (i = 0; i < 5; i++) begin
            par(1'b1, REC_CH0, 8'h00, bad[i]);
            chk("param err", 32'h1, {31'h0, param_err});
            smp(2'h0, 16'h0064);
            chk("dark value", 32'h0, q);
        end
        par(1'b1, REC_CH0, 8'h00, FN_OFF);
        chk("off no err", 32'h0, {31'h0, param_err});
        smp(2'h0, 16'h0064);
        chk("off value", 32'h0, q);
        par(1'b0, 8'h84, 8'h00, 8'h00);
        chk("bad record", 32'h1, {31'h0, e});
        ax(1'b0, 8'h40, 32'h0);
        chk("bad addr", {30'h0, RESP_ERR}, {30'h0, rs});
        ax(1'b1, 8'h40, 32'h0);
        chk("bad waddr", {30'h0, RESP_ERR}, {30'h0, rs});
        // two-channel strap turns channels 2 and 3 off at reset
        two_ch <= 1'b1;
        do_reset();
        for (i = 0; i < 4; i++) begin
            par(1'b0, 8'(REC_CH0 + i), 8'h00, 8'h00);
            chk("two ch code", i < 2 ? RST_FN : FN_OFF, b);
        end
        chk("two ch active", 32'h3, {28'h0, bp.ch_active});
        conclude();
    end
endmodule
